// File: design/stat_pkg.sv
package stat_pkg;

    localparam int ADDR_W = 12;
    localparam int CNT_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_TX_SEQ0 = 12'h60F;
    localparam logic [11:0] IDX_TX_SEQ1 = 12'h610;
    localparam logic [11:0] IDX_TX_SEQ2 = 12'h611;
    localparam logic [11:0] IDX_RX_SEQ0 = 12'h612;
    localparam logic [11:0] IDX_RX_SEQ1 = 12'h613;
    localparam logic [11:0] IDX_RX_SEQ2 = 12'h614;
    localparam logic [11:0] IDX_TX_FRAME_LOW = 12'h639;
    localparam logic [11:0] IDX_TX_FRAME_HIGH = 12'h63A;
    localparam logic [11:0] IDX_TX_CRC_FAULT = 12'h63B;
    localparam logic [11:0] IDX_RX_FRAME_LOW = 12'h63C;
    localparam logic [11:0] IDX_RX_FRAME_HIGH = 12'h63D;
    localparam logic [11:0] IDX_RX_CRC_FAULT = 12'h63E;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h640;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h641;

    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // Interrupt status bit positions
    localparam int IRQ_TX_WRAP = 0;
    localparam int IRQ_RX_WRAP = 1;
    localparam int IRQ_TX_CLR = 2;
    localparam int IRQ_RX_CLR = 3;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ONE = 2'b01,
        SEQ_TWO = 2'b11
    } seq_state_type;

    typedef struct packed {
        logic done;
        logic crc_bad;
    } frame_evt_type;

    typedef struct packed {
        logic [13:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
        logic cyc;
        logic stb;
    } wb_req_type;

endpackage : stat_pkg

// File: design/read_seq_detect.sv
`timescale 1ns/100ps
module read_seq_detect (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rd_strobe,
    input wire logic [11:0] rd_index,
    input wire logic [11:0] first_index,
    input wire logic [11:0] second_index,
    input wire logic [11:0] third_index,
    output logic clear_pulse
);
    import stat_pkg::*;

    typedef struct packed {
        seq_state_type st;
        logic clr;
    } seq_regs_type;

    seq_regs_type r_ff;
    seq_regs_type nxt_r;

    assign clear_pulse = r_ff.clr;

    // Any other read in between breaks the sequence
    always_comb begin
        nxt_r = r_ff;
        nxt_r.clr = 1'b0;
        if (rd_strobe) begin
            case (r_ff.st)
                SEQ_IDLE: begin
                    if (rd_index == first_index) nxt_r.st = SEQ_ONE;
                end
                SEQ_ONE: begin
                    if (rd_index == second_index) nxt_r.st = SEQ_TWO;
                    else if (rd_index == first_index) nxt_r.st = SEQ_ONE;
                    else nxt_r.st = SEQ_IDLE;
                end
                SEQ_TWO: begin
                    nxt_r.st = SEQ_IDLE;
                    if (rd_index == third_index) begin
                        nxt_r.clr = 1'b1;
                    end else if (rd_index == first_index) begin
                        nxt_r.st = SEQ_ONE;
                    end
                end
                default: nxt_r.st = SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r_ff <= '{st: SEQ_IDLE, clr: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    clear_after_third_a: assert property (@(posedge mclk) disable iff (rst)
        clear_pulse |-> $past(rd_strobe) && $past(rd_index) == third_index)
        else $error("clear without final read");

endmodule : read_seq_detect

// File: design/frame_counter.sv
`timescale 1ns/100ps
module frame_counter #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clear,
    input wire logic inc,
    output logic [WIDTH-1:0] count,
    output logic wrap
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic wrap;
    } cnt_regs_type;

    cnt_regs_type r_ff;
    cnt_regs_type nxt_r;

    assign count = r_ff.cnt;
    assign wrap = r_ff.wrap;

    // Frame in the clear cycle is dropped; the clear is the fresh start
    always_comb begin
        nxt_r = r_ff;
        nxt_r.wrap = 1'b0;
        if (clear) begin
            nxt_r.cnt = '0;
        end else if (inc) begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
            nxt_r.wrap = &r_ff.cnt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    step_by_one_a: assert property (@(posedge mclk) disable iff (rst)
        inc && !clear |=> count == $past(count) + 1'b1)
        else $error("counter did not step by one");

endmodule : frame_counter

// File: design/packet_statistics_counters.sv
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
// Behaviour
// R01 - 16-bit transmit CRC-fault frame count at 0x63B
// R02 - Reads 0x60F,0x610,0x611 clear transmit counters
// R03 - Received frame count low half at 0x63C
// R04 - Received frame count high half at 0x63D
// R05 - 16-bit receive CRC-fault frame count at 0x63E
// R06 - Reads 0x612,0x613,0x614 clear receive counters
// R07 - All counters read zero after reset
// R08 - 32-bit transmit frame count at 0x639/0x63A
// R09 - Count one per frame; clear after final read
module packet_statistics_counters (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [13:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire stat_pkg::frame_evt_type tx_frame,
    input wire stat_pkg::frame_evt_type rx_frame,
    output logic irq
);
    import stat_pkg::*;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
        logic err;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
        logic rd_strobe;
        logic [11:0] rd_index;
    } top_regs_type;

    top_regs_type r_ff;
    top_regs_type nxt_r;

    logic tx_clear;
    logic rx_clear;
    logic [31:0] tx_frames;
    logic [15:0] tx_faults;
    logic [31:0] rx_frames;
    logic [15:0] rx_faults;
    logic tx_wrap;
    logic rx_wrap;
    logic req;
    logic [11:0] idx;
    logic [31:0] rd_val;
    logic mapped;

    assign req = wb_cyc_i && wb_stb_i && !r_ff.ack && !r_ff.err;
    assign idx = wb_adr_i[13:2];

    // Sequence detectors watch completed reads one cycle late
    read_seq_detect tx_seq (
        .mclk(mclk),
        .rst(rst),
        .rd_strobe(r_ff.rd_strobe),
        .rd_index(r_ff.rd_index),
        .first_index(IDX_TX_SEQ0),
        .second_index(IDX_TX_SEQ1),
        .third_index(IDX_TX_SEQ2),
        .clear_pulse(tx_clear)
    ); // see R02 see R09

    read_seq_detect rx_seq (
        .mclk(mclk),
        .rst(rst),
        .rd_strobe(r_ff.rd_strobe),
        .rd_index(r_ff.rd_index),
        .first_index(IDX_RX_SEQ0),
        .second_index(IDX_RX_SEQ1),
        .third_index(IDX_RX_SEQ2),
        .clear_pulse(rx_clear)
    ); // see R06 see R09

    frame_counter #(.WIDTH(32)) tx_frame_cnt (
        .mclk(mclk),
        .rst(rst),
        .clear(tx_clear),
        .inc(tx_frame.done),
        .count(tx_frames),
        .wrap(tx_wrap)
    ); // see R08

    frame_counter #(.WIDTH(16)) tx_fault_cnt (
        .mclk(mclk),
        .rst(rst),
        .clear(tx_clear),
        .inc(tx_frame.done && tx_frame.crc_bad),
        .count(tx_faults),
        .wrap()
    ); // see R01

    frame_counter #(.WIDTH(32)) rx_frame_cnt (
        .mclk(mclk),
        .rst(rst),
        .clear(rx_clear),
        .inc(rx_frame.done),
        .count(rx_frames),
        .wrap(rx_wrap)
    ); // see R03 see R04

    frame_counter #(.WIDTH(16)) rx_fault_cnt (
        .mclk(mclk),
        .rst(rst),
        .clear(rx_clear),
        .inc(rx_frame.done && rx_frame.crc_bad),
        .count(rx_faults),
        .wrap()
    ); // see R05

    // Read mux; sequence addresses are mapped and read as zero
    always_comb begin
        rd_val = 32'h00000000;
        mapped = 1'b1;
        if (idx == IDX_TX_FRAME_LOW) begin
            rd_val = {16'h0000, tx_frames[15:0]}; // see R08
        end else if (idx == IDX_TX_FRAME_HIGH) begin
            rd_val = {16'h0000, tx_frames[31:16]}; // see R08
        end else if (idx == IDX_TX_CRC_FAULT) begin
            rd_val = {16'h0000, tx_faults}; // see R01
        end else if (idx == IDX_RX_FRAME_LOW) begin
            rd_val = {16'h0000, rx_frames[15:0]}; // see R03
        end else if (idx == IDX_RX_FRAME_HIGH) begin
            rd_val = {16'h0000, rx_frames[31:16]}; // see R04
        end else if (idx == IDX_RX_CRC_FAULT) begin
            rd_val = {16'h0000, rx_faults}; // see R05
        end else if (idx == IDX_IRQ_STATUS) begin
            rd_val = {28'h0000000, r_ff.irq_status};
        end else if (idx == IDX_IRQ_MASK) begin
            rd_val = {28'h0000000, r_ff.irq_mask};
        end else if (idx >= IDX_TX_SEQ0 && idx <= IDX_RX_SEQ2) begin
            rd_val = 32'h00000000;
        end else begin
            mapped = 1'b0;
        end
    end

    always_comb begin
        logic [3:0] events;
        logic rd_status;
        events = 4'h0;
        rd_status = 1'b0;
        nxt_r = r_ff;
        nxt_r.ack = 1'b0;
        nxt_r.err = 1'b0;
        nxt_r.rd_strobe = 1'b0;
        events[IRQ_TX_WRAP] = tx_wrap;
        events[IRQ_RX_WRAP] = rx_wrap;
        events[IRQ_TX_CLR] = tx_clear;
        events[IRQ_RX_CLR] = rx_clear;
        if (req) begin
            nxt_r.ack = mapped;
            nxt_r.err = !mapped;
            nxt_r.dat = rd_val;
            if (mapped && !wb_we_i) begin
                nxt_r.rd_strobe = 1'b1;
                nxt_r.rd_index = idx;
                rd_status = (idx == IDX_IRQ_STATUS);
            end
            if (mapped && wb_we_i && idx == IDX_IRQ_MASK && wb_sel_i[0]) begin
                nxt_r.irq_mask = wb_dat_i[3:0];
            end
        end
        // New events win over the read-to-clear
        nxt_r.irq_status = (rd_status ? 4'h0 : r_ff.irq_status) | events;
        nxt_r.irq = |(nxt_r.irq_status & nxt_r.irq_mask);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r_ff <= '{dat: 32'h00000000, ack: 1'b0, err: 1'b0,
                irq_status: IRQ_RESET, irq_mask: IRQ_RESET, irq: 1'b0,
                rd_strobe: 1'b0, rd_index: 12'h000}; // see R07
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign wb_dat_o = r_ff.dat;
    assign wb_ack_o = r_ff.ack;
    assign wb_err_o = r_ff.err;
    assign irq = r_ff.irq;

    ack_one_cycle_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    err_one_cycle_a: assert property (
        @(posedge mclk) disable iff (rst)
        wb_err_o
        |=> !wb_err_o)
        else $error("err held longer than one cycle");

    answer_next_a: assert property (
        @(posedge mclk) disable iff (rst)
        req && mapped
        |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not acknowledged");

    unmapped_err_a: assert property (
        @(posedge mclk) disable iff (rst)
        req && !mapped
        |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");

    idle_no_ack_a: assert property (
        @(posedge mclk) disable iff (rst)
        !(wb_cyc_i && wb_stb_i)
        |=> !wb_ack_o && !wb_err_o)
        else $error("answer without request");

    tx_clear_zero_a: assert property ( // see R02
        @(posedge mclk) disable iff (rst)
        tx_clear
        |=> tx_frames == 32'h00000000 && tx_faults == 16'h0000)
        else $error("tx counters not cleared");

    rx_clear_zero_a: assert property ( // see R06
        @(posedge mclk) disable iff (rst)
        rx_clear
        |=> rx_faults == 16'h0000 && rx_frames == 32'h00000000)
        else $error("rx counters not cleared");

    reset_hold_a: assert property ( // see R07
        @(posedge mclk)
        rst
        |=> tx_frames == 32'h00000000 && tx_faults == CNT_RESET
        && rx_frames == 32'h00000000 && rx_faults == CNT_RESET && !irq)
        else $error("counter not zero during reset");

    reset_zero_a: assert property ( // see R07
        @(posedge mclk)
        $past(rst) && !rst
        |-> tx_frames == 32'h00000000 && tx_faults == CNT_RESET
        && rx_frames == 32'h00000000 && rx_faults == CNT_RESET)
        else $error("counter not zero after reset");

    tx_low_read_a: assert property ( // see R08
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_TX_FRAME_LOW
        |=> wb_dat_o == {16'h0000, $past(tx_frames[15:0])})
        else $error("tx low half read wrong");

    tx_high_read_a: assert property ( // see R08
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_TX_FRAME_HIGH
        |=> wb_dat_o == {16'h0000, $past(tx_frames[31:16])})
        else $error("tx high half read wrong");

    tx_fault_read_a: assert property ( // see R01
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_TX_CRC_FAULT
        |=> wb_dat_o == {16'h0000, $past(tx_faults)})
        else $error("tx fault count read wrong");

    rx_low_read_a: assert property ( // see R03
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_RX_FRAME_LOW
        |=> wb_dat_o == {16'h0000, $past(rx_frames[15:0])})
        else $error("rx low half read wrong");

    rx_high_read_a: assert property ( // see R04
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_RX_FRAME_HIGH
        |=> wb_dat_o == {16'h0000, $past(rx_frames[31:16])})
        else $error("rx high half read wrong");

    rx_fault_read_a: assert property ( // see R05
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_RX_CRC_FAULT
        |=> wb_dat_o == {16'h0000, $past(rx_faults)})
        else $error("rx fault count read wrong");

    seq_read_zero_a: assert property ( // see R02 see R06
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx >= IDX_TX_SEQ0 && idx <= IDX_RX_SEQ2
        |=> wb_dat_o == 32'h00000000)
        else $error("sequence address did not read zero");

    tx_frame_step_a: assert property ( // see R08 see R09
        @(posedge mclk) disable iff (rst)
        tx_frame.done && !tx_clear
        |=> tx_frames == $past(tx_frames) + 32'h00000001)
        else $error("tx frame count did not step");

    tx_fault_step_a: assert property ( // see R01 see R09
        @(posedge mclk) disable iff (rst)
        tx_frame.done && tx_frame.crc_bad && !tx_clear
        |=> tx_faults == $past(tx_faults) + 16'h0001)
        else $error("tx fault count did not step");

    rx_frame_step_a: assert property ( // see R03 see R04 see R09
        @(posedge mclk) disable iff (rst)
        rx_frame.done && !rx_clear
        |=> rx_frames == $past(rx_frames) + 32'h00000001)
        else $error("rx frame count did not step");

    rx_fault_step_a: assert property ( // see R05 see R09
        @(posedge mclk) disable iff (rst)
        rx_frame.done && rx_frame.crc_bad && !rx_clear
        |=> rx_faults == $past(rx_faults) + 16'h0001)
        else $error("rx fault count did not step");

    tx_hold_a: assert property ( // see R09
        @(posedge mclk) disable iff (rst)
        !tx_frame.done && !tx_clear
        |=> tx_frames == $past(tx_frames) && tx_faults == $past(tx_faults))
        else $error("tx counters moved without a frame");

    rx_hold_a: assert property ( // see R09
        @(posedge mclk) disable iff (rst)
        !rx_frame.done && !rx_clear
        |=> rx_frames == $past(rx_frames) && rx_faults == $past(rx_faults))
        else $error("rx counters moved without a frame");

    status_clear_a: assert property (
        @(posedge mclk) disable iff (rst)
        req && !wb_we_i && idx == IDX_IRQ_STATUS
        && !tx_wrap && !rx_wrap && !tx_clear && !rx_clear
        |=> r_ff.irq_status == IRQ_RESET)
        else $error("status not cleared by read");

    clear_flag_set_a: assert property (
        @(posedge mclk) disable iff (rst)
        tx_clear
        |=> r_ff.irq_status[IRQ_TX_CLR])
        else $error("tx clear event lost");

    mask_write_a: assert property (
        @(posedge mclk) disable iff (rst)
        req && wb_we_i && idx == IDX_IRQ_MASK && wb_sel_i[0]
        |=> r_ff.irq_mask == $past(wb_dat_i[3:0]))
        else $error("mask write did not land");

    irq_level_a: assert property (
        @(posedge mclk) disable iff (rst)
        irq == |(r_ff.irq_status & r_ff.irq_mask))
        else $error("irq disagrees with status and mask");

    tx_clear_cov: cover property (@(posedge mclk) disable iff (rst)
        tx_clear);

    rx_clear_cov: cover property (@(posedge mclk) disable iff (rst)
        rx_clear);

    irq_cov: cover property (@(posedge mclk) disable iff (rst)
        irq);

    err_cov: cover property (@(posedge mclk) disable iff (rst)
        wb_err_o);

    tx_fault_cov: cover property (@(posedge mclk) disable iff (rst)
        tx_frame.done && tx_frame.crc_bad);

endmodule : packet_statistics_counters

// File: verification/test_packet_statistics_counters.sv
`timescale 1ns/100ps
module test_packet_statistics_counters;
    import stat_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] adr = 14'h0000;
    logic [31:0] wdat = 32'h00000000;
    logic [3:0] sel = 4'hF;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic err;
    logic irq;
    frame_evt_type tx_f = '0;
    frame_evt_type rx_f = '0;
    logic [32:0] exp_q[$];
    int error_cnt = 0;
    int check_count = 0;
    integer seed = 7011;
    logic [31:0] txn = 32'h0;
    logic [31:0] rxn = 32'h0;
    logic [15:0] txc = 16'h0;
    logic [15:0] rxc = 16'h0;
    logic [3:0] sts = 4'h0;

    always #12.5 mclk = ~mclk;

    packet_statistics_counters DUT (.mclk(mclk), .rst(rst), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .tx_frame(tx_f), .rx_frame(rx_f), .irq(irq));

    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        check_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // Holds the request until ack or err is sampled at a rising edge
    task automatic bus(input logic [11:0] idx, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        adr <= {idx, 2'b00};
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : bus

    task automatic rd(input logic [11:0] idx, input logic [31:0] e);
        exp_q.push_back({1'b0, e});
        bus(idx, 1'b0, 32'h0);
    endtask : rd

    // Read results matched in order of issue; writes are not queued
    always @(posedge mclk) begin
        if ((ack === 1'b1 || err === 1'b1) && we === 1'b0) begin
            if (exp_q.size() == 0) check({err, rdat}, 33'h1FFFFFFFF);
            else check({err, err ? 32'h0 : rdat}, exp_q.pop_front());
        end
    end

    task automatic frames(input bit tx, input int n);
        logic b;
        repeat (n) begin
            @(posedge mclk);
            b = 1'($random(seed));
            if (tx) tx_f <= '{done: 1'b1, crc_bad: b};
            else rx_f <= '{done: 1'b1, crc_bad: b};
            if (tx) txn = txn + 32'h1;
            else rxn = rxn + 32'h1;
            if (tx) txc = txc + {15'h0, b};
            else rxc = rxc + {15'h0, b};
            @(posedge mclk);
            tx_f <= '0;
            rx_f <= '0;
        end
    endtask : frames

    task automatic read_all();
        rd(IDX_TX_FRAME_LOW, {16'h0, txn[15:0]});
        rd(IDX_TX_FRAME_HIGH, {16'h0, txn[31:16]});
        rd(IDX_TX_CRC_FAULT, {16'h0, txc});
        rd(IDX_RX_FRAME_LOW, {16'h0, rxn[15:0]});
        rd(IDX_RX_FRAME_HIGH, {16'h0, rxn[31:16]});
        rd(IDX_RX_CRC_FAULT, {16'h0, rxc});
    endtask : read_all

    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        check({32'h0, irq}, {32'h0, e});
    endtask : irq_is

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        read_all();
        rd(IDX_IRQ_STATUS, 32'h0);
        rd(IDX_IRQ_MASK, 32'h0);
        $display("test reset values done");
        frames(1'b1, 1 + ($random(seed) & 15));
        frames(1'b0, 1 + ($random(seed) & 15));
        read_all();
        $display("test counting done");
        // Foreign read in mid-sequence must abort the clear
        rd(IDX_TX_SEQ0, 32'h0);
        rd(IDX_TX_SEQ1, 32'h0);
        rd(IDX_RX_CRC_FAULT, {16'h0, rxc});
        rd(IDX_TX_SEQ2, 32'h0);
        read_all();
        // A write inside the sequence neither breaks it nor lands
        rd(IDX_TX_SEQ0, 32'h0);
        bus(IDX_TX_CRC_FAULT, 1'b1, 32'h0000FFFF);
        rd(IDX_TX_SEQ1, 32'h0);
        rd(IDX_TX_SEQ2, 32'h0);
        txn = 32'h0;
        txc = 16'h0;
        sts[IRQ_TX_CLR] = 1'b1;
        repeat (2) @(posedge mclk);
        read_all();
        irq_is(1'b0);
        $display("test transmit clear done");
        rd(IDX_RX_SEQ0, 32'h0);
        rd(IDX_RX_SEQ1, 32'h0);
        rd(IDX_RX_SEQ2, 32'h0);
        rxn = 32'h0;
        rxc = 16'h0;
        sts[IRQ_RX_CLR] = 1'b1;
        repeat (2) @(posedge mclk);
        read_all();
        irq_is(1'b0);
        $display("test receive clear done");
        bus(IDX_IRQ_MASK, 1'b1, 32'h00000008);
        rd(IDX_IRQ_MASK, 32'h00000008);
        irq_is(1'b1);
        rd(IDX_IRQ_STATUS, {28'h0, sts});
        sts = 4'h0;
        irq_is(1'b0);
        rd(IDX_IRQ_STATUS, 32'h0);
        $display("test interrupt done");
        exp_q.push_back({1'b1, 32'h0});
        bus(12'h700, 1'b0, 32'h0);
        frames(1'b1, 1 + ($random(seed) & 31));
        frames(1'b0, 1 + ($random(seed) & 31));
        read_all();
        $display("test unmapped and recount done");
        print_verdict();
    end

    // Whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
endmodule : test_packet_statistics_counters
